// file: verilog/srl_params.svh
// Constants for the security register and block lock command logic.
// Assumes inclusion by srl_sec_lock.sv only; holds definitions and nothing else.
`ifndef SRL_PARAMS_SVH
`define SRL_PARAMS_SVH
`define SRL_OP_SEC_ERASE 8'h44
`define SRL_OP_SEC_PROG 8'h42
`define SRL_OP_SEC_READ 8'h48
`define SRL_OP_BLK_LOCK 8'h36
`define SRL_OP_BLK_UNLOCK 8'h39
`define SRL_OP_BLK_RDLOCK 8'h3D
`define SRL_MEM_DEPTH 768
`define SRL_REG_BYTES 256
`define SRL_ADDR_HI_SEC 8'h00
`define SRL_ADDR_MID_SEC 4'h0
`define SRL_ADDR_TOP_SEC 2'h0
`define SRL_ERASED 8'hFF
`define SRL_IDX_OPCODE 9'h000
`define SRL_IDX_A2 9'h001
`define SRL_IDX_A1 9'h002
`define SRL_IDX_A0 9'h003
`define SRL_IDX_DATA0 9'h004
`define SRL_IDX_DATA1 9'h005
`define SRL_IDX_MAX 9'h1FF
`define SRL_LOCK_PAD 7'h00
`define SRL_ERASE_CYCLES_DEF 6000
`define SRL_PROG_CYCLES_DEF 5000
`endif

// file: verilog/srl_pkg.sv
// Types shared by the security register and block lock command logic.
// Assumes nothing of its surroundings.
package srl_pkg;
    typedef enum logic [1:0] {EX_IDLE, EX_ERASE, EX_PROG} srl_exec_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } srl_tx_t;
    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
    } srl_cmd_t;
endpackage

// file: verilog/srl_sec_lock.sv
// Security register and individual block lock command logic of a serial flash.
// Assumes an SPI mode-0 host on spiClk/csN; the write enable command arrives as welSet and the status register lives outside.
`timescale 1ns/1ps
`include "srl_params.svh"

module srl_sec_lock #(
    parameter int ERASE_CYCLES = `SRL_ERASE_CYCLES_DEF,
    parameter int PROG_CYCLES = `SRL_PROG_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spiClk,
    input wire logic csN,
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe,
    input wire logic welSet,
    input wire logic [2:0] otpLockBits,
    input wire logic lockSchemeSelect,
    input wire logic rangeProtected,
    input wire logic [23:0] protQueryAddr,
    output logic writeEnableLatch,
    output logic busy,
    output logic protQueryLocked
);
    function automatic logic [1:0] secSel(input logic [23:0] a);
        secSel = 2'h0;
        if (a[23:16] == `SRL_ADDR_HI_SEC && a[11:8] == `SRL_ADDR_MID_SEC
            && a[15:14] == `SRL_ADDR_TOP_SEC)
        begin
            secSel = a[13:12];
        end
    endfunction

    function automatic logic [9:0] memIdx(input logic [1:0] sel, input logic [7:0] b);
        memIdx = {sel - 2'h1, b};
    endfunction

    // Link side: runs on the host's clock, which stops between frames.
    logic frameNew_q;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [7:0] rxShift_q, rxShift_d;
    logic [7:0] rxByte_q, rxByte_d;
    logic rxTog_q, rxTog_d;
    logic partial_q, partial_d;
    logic [7:0] txShift_q, txShift_d;
    logic txOn_q, txOn_d;
    logic doOut_q, doOe_q;
    srl_pkg::srl_tx_t tx_q, tx_d;

    always_ff @(posedge spiClk or posedge rst or posedge csN)
    begin
        if (rst || csN)
        begin
            frameNew_q <= 1'b1;
        end
        else
        begin
            frameNew_q <= 1'b0;
        end
    end

    always_comb
    begin
        logic [2:0] cnt;
        cnt = frameNew_q ? 3'h0 : bitCnt_q;
        bitCnt_d = cnt + 3'h1;
        rxShift_d = {rxShift_q[6:0], serialInPin};
        rxByte_d = rxByte_q;
        rxTog_d = rxTog_q;
        partial_d = (bitCnt_d != 3'h0);
        txShift_d = txShift_q;
        txOn_d = frameNew_q ? 1'b0 : txOn_q;
        if (bitCnt_d == 3'h0)
        begin
            rxByte_d = rxShift_d;
            rxTog_d = ~rxTog_q;
            // The system side rewrites tx_q only at a chip select fall or just after a byte toggle,
            // so it is settled for most of a byte time before this load.
            txShift_d = tx_q.data;
            txOn_d = tx_q.valid;
        end
    end

    always_ff @(posedge spiClk or posedge rst)
    begin
        if (rst)
        begin
            bitCnt_q <= 3'h0;
            rxShift_q <= 8'h00;
            rxByte_q <= 8'h00;
            rxTog_q <= 1'b0;
            partial_q <= 1'b0;
            txShift_q <= 8'h00;
            txOn_q <= 1'b0;
        end
        else
        begin
            bitCnt_q <= bitCnt_d;
            rxShift_q <= rxShift_d;
            rxByte_q <= rxByte_d;
            rxTog_q <= rxTog_d;
            partial_q <= partial_d;
            txShift_q <= txShift_d;
            txOn_q <= txOn_d;
        end
    end

    always_ff @(negedge spiClk or posedge rst or posedge csN)
    begin
        if (rst || csN)
        begin
            doOut_q <= 1'b0;
            doOe_q <= 1'b0;
        end
        else
        begin
            doOut_q <= txShift_q[~bitCnt_q];
            doOe_q <= txOn_q;
        end
    end

    assign serialOutPin = doOut_q;
    assign serialOutOe = doOe_q;

    // System side.
    logic csS1, csS2, csS3, togS1, togS2, togS3, partS1, partS2, execPend_q;
    logic csFall, csRise, newByte;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {csS1, csS2, csS3} <= 3'h7;
            {togS1, togS2, togS3} <= 3'h0;
            {partS1, partS2} <= 2'h0;
            execPend_q <= 1'b0;
        end
        else
        begin
            {csS1, csS2, csS3} <= {csN, csS1, csS2};
            {togS1, togS2, togS3} <= {rxTog_q, togS1, togS2};
            {partS1, partS2} <= {partial_q, partS1};
            execPend_q <= csRise;
        end
    end

    assign csFall = csS3 && !csS2;
    assign csRise = !csS3 && csS2;
    assign newByte = togS2 ^ togS3;

    logic [7:0] secMem [0:`SRL_MEM_DEPTH-1];
    logic [7:0] progBuf [0:`SRL_REG_BYTES-1];
    srl_pkg::srl_cmd_t cmd_q, cmd_d;
    srl_pkg::srl_exec_t exec_q, exec_d;
    logic [8:0] byteIdx_q, byteIdx_d;
    logic [7:0] progPtr_q, progPtr_d, rdPtr_q, rdPtr_d;
    logic [255:0] progMask_q, progMask_d, lockBits_q, lockBits_d;
    logic [8:0] walk_q, walk_d;
    logic [15:0] timer_q, timer_d;
    logic [1:0] selQ_q, selQ_d;
    logic wel_q, wel_d, busy_q, busy_d, prot_q, prot_d, lockHit;
    logic memWe, bufWe;
    logic [9:0] memWa;
    logic [7:0] memWd, bufWa, bufWd;

    assign lockHit = lockBits_q[protQueryAddr[23:16]];

    always_comb
    begin
        logic [1:0] sel;
        logic [23:0] fullAddr;
        logic okPrefix;
        sel = secSel(cmd_q.addr);
        fullAddr = {cmd_q.addr[23:8], rxByte_q};
        okPrefix = wel_q && !busy_q && !partS2;
        cmd_d = cmd_q;
        exec_d = exec_q;
        byteIdx_d = byteIdx_q;
        progPtr_d = progPtr_q;
        rdPtr_d = rdPtr_q;
        progMask_d = progMask_q;
        lockBits_d = lockBits_q;
        walk_d = walk_q;
        timer_d = timer_q;
        selQ_d = selQ_q;
        wel_d = wel_q;
        tx_d = tx_q;
        memWe = 1'b0;
        memWa = memIdx(selQ_q, walk_q[7:0]);
        memWd = `SRL_ERASED;
        bufWe = 1'b0;
        bufWa = progPtr_q;
        bufWd = rxByte_q;
        if (csFall)
        begin
            byteIdx_d = `SRL_IDX_OPCODE;
            tx_d = '0;
            if (exec_q == srl_pkg::EX_IDLE)
            begin
                progMask_d = '0;
            end
        end
        if (newByte)
        begin
            if (byteIdx_q != `SRL_IDX_MAX)
            begin
                byteIdx_d = byteIdx_q + 9'h001;
            end
            if (byteIdx_q == `SRL_IDX_OPCODE)
            begin
                cmd_d.op = rxByte_q;
            end
            else if (byteIdx_q == `SRL_IDX_A2)
            begin
                cmd_d.addr[23:16] = rxByte_q;
            end
            else if (byteIdx_q == `SRL_IDX_A1)
            begin
                cmd_d.addr[15:8] = rxByte_q;
                // Lock granularity is the top address byte, so the answer is
                // ready a full byte before it must be shifted out.
                if (cmd_q.op == `SRL_OP_BLK_RDLOCK)
                begin
                    tx_d.valid = 1'b1;
                    tx_d.data = {`SRL_LOCK_PAD, lockBits_q[cmd_q.addr[23:16]]};
                end
            end
            else if (byteIdx_q == `SRL_IDX_A0)
            begin
                cmd_d.addr[7:0] = rxByte_q;
                progPtr_d = rxByte_q;
                if (cmd_q.op == `SRL_OP_SEC_READ && !busy_q && secSel(fullAddr) != 2'h0)
                begin
                    tx_d.valid = 1'b1;
                    tx_d.data = secMem[memIdx(secSel(fullAddr), rxByte_q)];
                    rdPtr_d = rxByte_q + 8'h01;
                end
            end
            else if (cmd_q.op == `SRL_OP_SEC_PROG && exec_q == srl_pkg::EX_IDLE)
            begin
                bufWe = 1'b1;
                progMask_d[progPtr_q] = 1'b1;
                progPtr_d = progPtr_q + 8'h01;
            end
            else if (cmd_q.op == `SRL_OP_SEC_READ && tx_q.valid)
            begin
                tx_d.data = secMem[memIdx(sel, rdPtr_q)];
                rdPtr_d = rdPtr_q + 8'h01;
            end
        end
        if (execPend_q && okPrefix)
        begin
            if (cmd_q.op == `SRL_OP_SEC_ERASE && byteIdx_q == `SRL_IDX_DATA0
                && sel != 2'h0 && !otpLockBits[2'(sel - 2'h1)])
            begin
                exec_d = srl_pkg::EX_ERASE;
                timer_d = 16'(ERASE_CYCLES);
                walk_d = 9'h000;
                selQ_d = sel;
            end
            else if (cmd_q.op == `SRL_OP_SEC_PROG && byteIdx_q >= `SRL_IDX_DATA1
                && sel != 2'h0 && !otpLockBits[2'(sel - 2'h1)])
            begin
                exec_d = srl_pkg::EX_PROG;
                timer_d = 16'(PROG_CYCLES);
                walk_d = 9'h000;
                selQ_d = sel;
            end
            else if (cmd_q.op == `SRL_OP_BLK_LOCK && byteIdx_q == `SRL_IDX_DATA0)
            begin
                lockBits_d[cmd_q.addr[23:16]] = 1'b1;
                wel_d = 1'b0;
            end
            else if (cmd_q.op == `SRL_OP_BLK_UNLOCK && byteIdx_q == `SRL_IDX_DATA0)
            begin
                lockBits_d[cmd_q.addr[23:16]] = 1'b0;
                wel_d = 1'b0;
            end
        end
        if (exec_q != srl_pkg::EX_IDLE)
        begin
            // Only the selected 256-byte slice is touched.
            if (!walk_q[8])
            begin
                walk_d = walk_q + 9'h001;
                if (exec_q == srl_pkg::EX_ERASE)
                begin
                    memWe = 1'b1;
                end
                else if (progMask_q[walk_q[7:0]])
                begin
                    memWe = 1'b1;
                    memWd = secMem[memWa] & progBuf[walk_q[7:0]];
                end
            end
            timer_d = timer_q - 16'h0001;
            if (timer_q == 16'h0001)
            begin
                exec_d = srl_pkg::EX_IDLE;
                wel_d = 1'b0;
            end
        end
        // A write enable arriving as a cycle ends still counts.
        if (welSet)
        begin
            wel_d = 1'b1;
        end
        busy_d = (exec_d != srl_pkg::EX_IDLE);
        prot_d = lockSchemeSelect ? lockHit : rangeProtected;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_q <= '0;
            exec_q <= srl_pkg::EX_IDLE;
            byteIdx_q <= `SRL_IDX_OPCODE;
            progPtr_q <= 8'h00;
            rdPtr_q <= 8'h00;
            progMask_q <= '0;
            lockBits_q <= '1;
            walk_q <= 9'h000;
            timer_q <= 16'h0000;
            selQ_q <= 2'h0;
            wel_q <= 1'b0;
            busy_q <= 1'b0;
            prot_q <= 1'b1;
            tx_q <= '0;
        end
        else
        begin
            cmd_q <= cmd_d;
            exec_q <= exec_d;
            byteIdx_q <= byteIdx_d;
            progPtr_q <= progPtr_d;
            rdPtr_q <= rdPtr_d;
            progMask_q <= progMask_d;
            lockBits_q <= lockBits_d;
            walk_q <= walk_d;
            timer_q <= timer_d;
            selQ_q <= selQ_d;
            wel_q <= wel_d;
            busy_q <= busy_d;
            prot_q <= prot_d;
            tx_q <= tx_d;
        end
    end

    // Arrays carry no reset; secMem is undefined until first erased, progBuf until first written.
    always_ff @(posedge sys_clk)
    begin
        if (memWe)
        begin
            secMem[memWa] <= memWd;
        end
        if (bufWe)
        begin
            progBuf[bufWa] <= bufWd;
        end
    end

    assign writeEnableLatch = wel_q;
    assign busy = busy_q;
    assign protQueryLocked = prot_q;

    a_erase_accept: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(exec_q == srl_pkg::EX_ERASE) |-> $past(wel_q) && !$past(partS2)
        && $past(byteIdx_q) == `SRL_IDX_DATA0)
        else $error("erase started without latch, boundary or exact length");
    a_otp_guard: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(exec_q != srl_pkg::EX_IDLE) |-> !otpLockBits[2'(selQ_q - 2'h1)])
        else $error("cycle started on a one-time locked register");
    a_sel_defined: assert property (@(posedge sys_clk) disable iff (rst)
        exec_q != srl_pkg::EX_IDLE |-> selQ_q != 2'h0)
        else $error("cycle running on an undefined register code");
    a_busy_hold: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(exec_q == srl_pkg::EX_ERASE) |-> busy_q [*8])
        else $error("busy dropped early in an erase");
    a_wel_cleared: assert property (@(posedge sys_clk) disable iff (rst)
        (exec_q == srl_pkg::EX_ERASE && timer_q == 16'h0001 && !welSet) |=> !wel_q && !busy_q)
        else $error("latch or busy not cleared at erase end");
    a_read_idle: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(tx_q.valid) && cmd_q.op == `SRL_OP_SEC_READ) |-> !$past(busy_q))
        else $error("security read answered while busy");
    a_lock_byte: assert property (@(posedge sys_clk) disable iff (rst)
        (tx_q.valid && cmd_q.op == `SRL_OP_BLK_RDLOCK) |-> tx_q.data[7:1] == `SRL_LOCK_PAD)
        else $error("lock byte has upper bits set");
    a_prot_select: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> protQueryLocked == ($past(lockSchemeSelect) ? $past(lockHit)
        : $past(rangeProtected)))
        else $error("protection source wrong");
    a_erase_fill: assert property (@(posedge sys_clk) disable iff (rst)
        (exec_q == srl_pkg::EX_ERASE && !walk_q[8]) |-> memWe && memWd == `SRL_ERASED
        ##1 walk_q != 9'h000)
        else $error("erase walk not writing erased value");
endmodule

// file: tb/srl_host_model.sv
// Mode-0 SPI host model that drives the link of the security register and block lock logic.
// Assumes the bench fills txQ, calls frame() and afterwards reads rxQ and oeCnt.
`timescale 1ns/1ps
module srl_host_model (
    output logic spiClk,
    output logic csN,
    output logic serialInPin,
    input wire logic serialOutPin,
    input wire logic serialOutOe
);
    logic [7:0] txQ[$];
    logic [7:0] rxQ[$];
    int oeCnt;

    initial
    begin
        spiClk = 1'b0;
        csN = 1'b1;
        serialInPin = 1'b1;
    end

    // Data moves while the clock is low, so it is settled at the rising edge.
    task automatic clk_bit(input logic b, output logic got);
        serialInPin = b;
        #80 spiClk = 1'b1;
        got = serialOutPin;
        if (serialOutOe === 1'b1)
            oeCnt++;
        #80 spiClk = 1'b0;
    endtask

    // The clock stands still between frames and the data line shows the inverse of its last bit.
    task automatic frame(input logic [31:0] cmd, input int nRd, input int tail);
        logic b;
        logic [7:0] v;
        rxQ = {};
        oeCnt = 0;
        csN = 1'b0;
        // The odd lead keeps link edges off the system clock edges.
        #43;
        for (int i = 31; i >= 0; i--)
            clk_bit(cmd[i], b);
        while (txQ.size() > 0)
        begin
            v = txQ.pop_front();
            for (int i = 7; i >= 0; i--)
                clk_bit(v[i], b);
        end
        for (int n = 0; n < nRd; n++)
        begin
            for (int i = 7; i >= 0; i--)
            begin
                clk_bit(~serialInPin, b);
                v[i] = b;
            end
            rxQ.push_back(v);
        end
        for (int i = 0; i < tail; i++)
            clk_bit(~serialInPin, b);
        #40 csN = 1'b1;
        serialInPin = ~serialInPin;
        #200;
    endtask
endmodule

// file: tb/test_srl_sec_lock.sv
// Self-checking bench for the security register and block lock logic.
// Assumes srl_host_model on the link and an integer reference model kept here.
`timescale 1ns/1ps
module test_srl_sec_lock;
    localparam int CYC = 2000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic spiClk, csN, serialInPin, serialOutPin, serialOutOe;
    logic welSet = 1'b0;
    logic [2:0] otpLockBits = 3'h0;
    logic lockSchemeSelect = 1'b1;
    logic rangeProtected = 1'b0;
    logic [23:0] protQueryAddr = 24'h00_0000;
    logic writeEnableLatch, busy, protQueryLocked;
    int bad_count = 0;
    int n_checks = 0;
    int mem[768];
    int lockBit[256];
    logic [31:0] rng = 32'h0000_7A61;

    always #5 sys_clk = ~sys_clk;

    srl_sec_lock #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) u_srl_sec_lock (
        .sys_clk(sys_clk), .rst(rst), .spiClk(spiClk), .csN(csN), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialOutOe(serialOutOe), .welSet(welSet),
        .otpLockBits(otpLockBits), .lockSchemeSelect(lockSchemeSelect),
        .rangeProtected(rangeProtected), .protQueryAddr(protQueryAddr),
        .writeEnableLatch(writeEnableLatch), .busy(busy), .protQueryLocked(protQueryLocked));

    srl_host_model u_srl_host_model (.spiClk(spiClk), .csN(csN), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialOutOe(serialOutOe));

    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [23:0] sec_addr(input int r, input int a);
        return {8'h00, r[3:0], 4'h0, a[7:0]};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic set_wel();
        @(negedge sys_clk) welSet = 1'b1;
        @(negedge sys_clk) welSet = 1'b0;
        check("writeEnableLatch set", writeEnableLatch, 1'b1);
    endtask

    // A refused command must leave busy low; an accepted one must end with the latch clear.
    task automatic wait_cycle(input logic started);
        int n;
        for (n = 0; n < 20 && busy !== 1'b1; n++)
            @(negedge sys_clk);
        check("busy start", busy, started);
        for (n = 0; n < CYC + 50 && busy !== 1'b0; n++)
            @(negedge sys_clk);
        check("busy end", busy, 1'b0);
        if (started)
            check("writeEnableLatch clear", writeEnableLatch, 1'b0);
    endtask

    task automatic sec_write(input logic [7:0] op, input int r, input int a, input int n,
        input int tail, input logic ok);
        logic [7:0] d;
        for (int i = 0; i < n; i++)
        begin
            d = 8'(next_rand());
            u_srl_host_model.txQ.push_back(d);
            if (ok)
                mem[(r - 1) * 256 + (a + i) % 256] &= d;
        end
        if (ok && op == 8'h44)
            for (int i = 0; i < 256; i++)
                mem[(r - 1) * 256 + i] = 255;
        u_srl_host_model.frame({op, sec_addr(r, a)}, 0, tail);
    endtask

    task automatic sec_read(input int r, input int a, input int n, input logic ok);
        u_srl_host_model.txQ.push_back(8'h5A);
        u_srl_host_model.frame({8'h48, sec_addr(r, a)}, n, 0);
        check("read drive bits", u_srl_host_model.oeCnt, ok ? 8 * n : 0);
        for (int i = 0; ok && i < n; i++)
            check("read byte", u_srl_host_model.rxQ[i], mem[(r - 1) * 256 + (a + i) % 256]);
    endtask

    task automatic lock_read(input int b);
        u_srl_host_model.frame({8'h3D, b[7:0], 16'h1234}, 2, 0);
        check("lock drive bits", u_srl_host_model.oeCnt, 16);
        for (int i = 0; i < 2; i++)
            check("lock byte", u_srl_host_model.rxQ[i], lockBit[b]);
    endtask

    task automatic query(input int b, input logic scheme, input logic range);
        @(negedge sys_clk);
        lockSchemeSelect = scheme;
        rangeProtected = range;
        protQueryAddr = {b[7:0], 16'h0FF0};
        @(negedge sys_clk);
        check("protQueryLocked", protQueryLocked, scheme ? lockBit[b] : range);
    endtask

    initial
    begin
        // The scenarios need about 41,000 system cycles; this leaves ample margin.
        #700_000;
        bad_count++;
        complete_run();
    end

    initial
    begin
        for (int i = 0; i < 256; i++)
            lockBit[i] = 1;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        check("writeEnableLatch reset", writeEnableLatch, 1'b0);
        check("busy reset", busy, 1'b0);
        check("query reset", protQueryLocked, 1'b1);
        foreach (lockBit[b])
            if (b % 85 == 0)
                lock_read(b);
        for (int r = 1; r <= 3; r++)
        begin
            set_wel();
            sec_write(8'h44, r, next_rand() % 256, 0, 0, 1);
            wait_cycle(1);
        end
        for (int r = 2; r <= 3; r++)
        begin
            set_wel();
            sec_write(8'h42, r, 254, 4, 0, 1);
            wait_cycle(1);
            sec_read(r, 253, 6, 1);
        end
        sec_read(1, 0, 2, 1);
        sec_write(8'h42, 1, 16, 1, 0, 0);
        wait_cycle(0);
        set_wel();
        sec_write(8'h42, 1, 16, 1, 0, 1);
        wait_cycle(1);
        sec_write(8'h44, 1, 0, 0, 0, 0);
        wait_cycle(0);
        set_wel();
        sec_write(8'h44, 1, 0, 0, 3, 0);
        wait_cycle(0);
        @(negedge sys_clk) otpLockBits = 3'h1;
        sec_write(8'h44, 1, 0, 0, 0, 0);
        wait_cycle(0);
        sec_write(8'h42, 1, 16, 1, 0, 0);
        wait_cycle(0);
        sec_read(1, 15, 3, 1);
        for (int r = 0; r <= 4; r += 4)
        begin
            sec_write(8'h42, r, 0, 1, 0, 0);
            wait_cycle(0);
            sec_read(r, 0, 1, 0);
        end
        sec_write(8'h44, 3, 0, 0, 0, 1);
        sec_read(3, 0, 1, 0);
        lock_read(7);
        wait_cycle(1);
        sec_read(3, 254, 2, 1);
        for (int k = 0; k < 4; k++)
        begin
            int b;
            b = next_rand() % 256;
            set_wel();
            lockBit[b] = k % 2;
            u_srl_host_model.frame({(k % 2) ? 8'h36 : 8'h39, b[7:0], 16'hABCD}, 0, 0);
            check("writeEnableLatch after lock", writeEnableLatch, 1'b0);
            lock_read(b);
            query(b, 1'b1, 1'b0);
            query(b, 1'b0, next_rand() % 2);
        end
        // A reset in mid-run must bring every block lock back to one.
        @(negedge sys_clk);
        rst = 1'b1;
        lockSchemeSelect = 1'b1;
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        foreach (lockBit[i])
            lockBit[i] = 1;
        repeat (2) @(negedge sys_clk);
        check("writeEnableLatch after reset", writeEnableLatch, 1'b0);
        check("query after reset", protQueryLocked, 1'b1);
        u_srl_host_model.frame({8'h39, 8'h22, 16'h0000}, 0, 0);
        lock_read(8'h22);
        complete_run();
    end
endmodule
